/* File: rtl/nvc_map.vh */
// Purpose: constants for the host controller of the nonvolatile static memory
// Assumes: clk_sys at 20 MHz (50 ns period)
// Notes:   definitions only
`ifndef NVC_MAP_VH
`define NVC_MAP_VH
`define NVC_CLK_NS          32'd50
// command address words (compared on bits 14..2)
`define NVC_SEQ_A1          16'h4E38
`define NVC_SEQ_A2          16'hB1C7
`define NVC_SEQ_A3          16'h83E0
`define NVC_SEQ_A4          16'h7C1F
`define NVC_SEQ_A5          16'h703F
`define NVC_CMD_SAVE        16'h8FC0
`define NVC_CMD_RESTORE     16'h4C63
`define NVC_CMD_PLS_OFF     16'h8B45
`define NVC_CMD_PLS_ON      16'h4B46
// command codes on cmd_op
`define NVC_OP_SAVE         2'h0
`define NVC_OP_RESTORE      2'h1
`define NVC_OP_PLS_OFF      2'h2
`define NVC_OP_PLS_ON       2'h3
// times
`define NVC_T_CYCLE_NS      32'd50
`define NVC_T_REQ_PULSE_NS  32'd15
`define NVC_T_SAVE_US       32'd8000
`define NVC_T_RESTORE_US    32'd200
`define NVC_T_SEQ_ACT_US    32'd100
`define NVC_T_POWERUP_US    32'd20000
`define NVC_T_BUSY_REL_NS   32'd500
`endif

/* File: rtl/nvc_phase.v */
// Purpose: counts phases of one bus access for the host controller
// Assumes: clock enable freezes the count
// Notes:   cnt_done pulses when count reaches limit
`timescale 1ns/1ps
module nvc_phase #(
   parameter W = 24
) (
   clk_sys,
   rst,
   ce,
   start,
   limit,
   busy,
   cnt_done
);
   input  wire         clk_sys;
   input  wire         rst;
   input  wire         ce;
   input  wire         start;
   input  wire [W-1:0] limit;
   output wire         busy;
   output wire         cnt_done;

   reg [W-1:0] cnt_r;
   reg         run_r;

   assign busy     = run_r;
   assign cnt_done = run_r & (cnt_r >= limit);

   // counter runs from start until limit, then stops
   always @(posedge clk_sys) begin
      if (rst) begin
         cnt_r <= {W{1'b0}};
         run_r <= 1'b0;
      end else if (ce) begin
         if (start) begin
            cnt_r <= {W{1'b0}};
            run_r <= 1'b1;
         end else if (cnt_done) begin
            run_r <= 1'b0;
         end else if (run_r) begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // nvc_phase

/* File: rtl/nvc_host.v */
// Purpose: host controller driving the nonvolatile static memory over its pins
// Assumes: one clock, pins synchronous to clk_sys; device ready after power-up wait
// Notes:
// Notes on behaviour
// R1: device deselected on chip select high; select low reads, gates or writes by strobes.
// R2: host keeps the busy line released high during every read and write.
// R3: write strobe stays high for the whole of every read.
// R4: write strobe low at select fall keeps device outputs off; host does this on every write.
// R5: device skips hardware save when nothing was written since last cycle.
// R6: device still takes a write in flight for 25 ns after a save trigger.
// R7: device ignores accesses during save, restore and low supply.
// R8: power-up restore finishes within 20 ms after supply is good.
// R9: save locks accesses up to 8 ms, software restore up to 200 us.
// R10: device acts on a command sequence within 100 us.
// R11: each command step is one select-timed read of one address.
// R12: six command reads consecutive, in order, write strobe high on all.
// R13: data of the sixth command read is discarded.
// R14: hardware save request holds the busy line low at least 15 ns.
// R15: with no pending write the device returns outputs within 25 ns.
// R16: device drives busy high up to 500 ns after save, then releases it.
// R17: command prefix reads 4E38, B1C7, 83E0, 7C1F, 703F.
// R18: sixth address selects save, restore, power-loss save off or on.
// R19: only address bits 14 to 2 are decoded by the device.
// R20: busy line low from outside requests a save; device holds it low meanwhile.
// R21: device restarts sequence on mismatch or intervening write.
// R22: during hardware save busy stays low and device outputs stay off.
`timescale 1ns/1ps
`include "nvc_map.vh"
module nvc_host #(
   parameter AW          = 19,
   parameter CLK_NS      = 50,
   parameter POWERUP_CYC = ((`NVC_T_POWERUP_US * 1000) / CLK_NS),
   parameter SAVE_CYC    = ((`NVC_T_SAVE_US * 1000) / CLK_NS),
   parameter RESTORE_CYC = ((`NVC_T_RESTORE_US * 1000) / CLK_NS)
) (
   clk_sys,
   rst,
   ce,
   req_valid,
   req_ready,
   req_write,
   req_addr,
   req_wdata,
   rsp_valid,
   rsp_rdata,
   cmd_valid,
   cmd_ready,
   cmd_op,
   hw_save_req,
   dev_ready,
   mem_addr,
   mem_cs_n,
   mem_we_n,
   mem_oe_n,
   byte_lines_i,
   byte_lines_o,
   byte_lines_oe,
   busy_line_i,
   busy_line_o,
   busy_line_oe
);
   input  wire          clk_sys;
   input  wire          rst;
   input  wire          ce;
   input  wire          req_valid;
   output wire          req_ready;
   input  wire          req_write;
   input  wire [AW-1:0] req_addr;
   input  wire [7:0]    req_wdata;
   output reg           rsp_valid;
   output reg  [7:0]    rsp_rdata;
   input  wire          cmd_valid;
   output wire          cmd_ready;
   input  wire [1:0]    cmd_op;
   input  wire          hw_save_req;
   output wire          dev_ready;
   output reg  [AW-1:0] mem_addr;
   output reg           mem_cs_n;
   output reg           mem_we_n;
   output reg           mem_oe_n;
   input  wire [7:0]    byte_lines_i;
   output reg  [7:0]    byte_lines_o;
   output reg           byte_lines_oe;
   input  wire          busy_line_i;
   output wire          busy_line_o;
   output reg           busy_line_oe;

   // select stays low three cycles (150 ns), well above 45 ns cycle and 30 ns pulse limits
   localparam [23:0] ACC_CYC  = 24'd1;
   // counts are worked out at full width, then cut to the counter width on purpose
   localparam        REQ_N    = ((`NVC_T_REQ_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam        BREL_N   = ((`NVC_T_BUSY_REL_NS + CLK_NS - 1) / CLK_NS);
   localparam        SEQ_N    = ((`NVC_T_SEQ_ACT_US * 1000) / CLK_NS);
   localparam [23:0] REQ_CYC  = REQ_N[23:0];
   localparam [23:0] BREL_CYC = BREL_N[23:0];
   localparam [23:0] SEQ_CYC  = SEQ_N[23:0];

   // one-hot states
   localparam [6:0] S_PWR  = 7'h01;
   localparam [6:0] S_IDLE = 7'h02;
   localparam [6:0] S_ACC  = 7'h04;
   localparam [6:0] S_GAP  = 7'h08;
   localparam [6:0] S_HREQ = 7'h10;
   localparam [6:0] S_HWT  = 7'h20;
   localparam [6:0] S_LOCK = 7'h40;

   reg  [6:0]  st_r;
   reg  [6:0]  st_nxt;
   reg  [2:0]  step_r;       // command read index 0..5
   reg         cmd_act_r;
   reg  [1:0]  op_r;
   reg         wr_r;
   reg  [23:0] lim_r;
   reg         start_r;
   wire        ph_busy;
   wire        ph_done;

   // address of a command step; only bits 14..2 matter to the device
   function [15:0] seq_word;
      input [2:0] s;
      input [1:0] op;
      begin
         case (s)
            3'h0: seq_word = `NVC_SEQ_A1;                              // [R17]
            3'h1: seq_word = `NVC_SEQ_A2;
            3'h2: seq_word = `NVC_SEQ_A3;
            3'h3: seq_word = `NVC_SEQ_A4;
            3'h4: seq_word = `NVC_SEQ_A5;
            default: begin
               case (op)                                                // [R18]
                  `NVC_OP_SAVE:    seq_word = `NVC_CMD_SAVE;
                  `NVC_OP_RESTORE: seq_word = `NVC_CMD_RESTORE;
                  `NVC_OP_PLS_OFF: seq_word = `NVC_CMD_PLS_OFF;
                  default:         seq_word = `NVC_CMD_PLS_ON;
               endcase
            end
         endcase
      end
   endfunction

   // lockout length after a command
   function [23:0] lock_len;
      input [1:0] op;
      begin
         case (op)
            `NVC_OP_SAVE:    lock_len = SAVE_CYC[23:0];                 // [R9]
            `NVC_OP_RESTORE: lock_len = RESTORE_CYC[23:0];              // [R9]
            default:         lock_len = SEQ_CYC;                        // [R10]
         endcase
      end
   endfunction

   nvc_phase #(
      .W        (24)
   ) u_phase (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .ce       (ce),
      .start    (start_r),
      .limit    (lim_r),
      .busy     (ph_busy),
      .cnt_done (ph_done)
   );

   assign req_ready   = ce & st_r[1] & ~cmd_valid & ~hw_save_req;
   assign cmd_ready   = ce & st_r[1] & ~hw_save_req;
   assign dev_ready   = st_r[1];
   assign busy_line_o = 1'b0;   // host only ever pulls low; released otherwise [R2]

   // next state
   always @* begin
      st_nxt = st_r;
      case (st_r)
         S_PWR:  if (ph_done) st_nxt = S_IDLE;                          // [R8]
         S_IDLE: begin
            if (hw_save_req)    st_nxt = S_HREQ;
            else if (cmd_valid) st_nxt = S_ACC;
            else if (req_valid) st_nxt = S_ACC;
         end
         S_ACC:  if (ph_done) st_nxt = S_GAP;
         S_GAP: begin
            if (cmd_act_r && step_r != 3'h5) st_nxt = S_ACC;            // [R12]
            else if (cmd_act_r)              st_nxt = S_LOCK;           // [R9]
            else                             st_nxt = S_IDLE;
         end
         S_HREQ: if (ph_done) st_nxt = S_HWT;                           // [R14]
         S_HWT:  if (busy_line_i) st_nxt = S_LOCK;                      // [R22]
         S_LOCK: if (ph_done) st_nxt = S_IDLE;                          // [R7]
         default: st_nxt = S_IDLE;
      endcase
   end

   // state, pins and counter control
   always @(posedge clk_sys) begin
      if (rst) begin
         st_r          <= S_PWR;
         step_r        <= 3'h0;
         cmd_act_r     <= 1'b0;
         op_r          <= `NVC_OP_SAVE;
         wr_r          <= 1'b0;
         lim_r         <= POWERUP_CYC[23:0];
         start_r       <= 1'b1;
         mem_addr      <= {AW{1'b0}};
         mem_cs_n      <= 1'b1;                                         // [R1]
         mem_we_n      <= 1'b1;
         mem_oe_n      <= 1'b1;
         byte_lines_o  <= 8'h00;
         byte_lines_oe <= 1'b0;
         busy_line_oe  <= 1'b0;
         rsp_valid     <= 1'b0;
         rsp_rdata     <= 8'h00;
      end else if (ce) begin
         st_r      <= st_nxt;
         start_r   <= 1'b0;
         rsp_valid <= 1'b0;
         case (st_r)
            S_IDLE: begin
               if (hw_save_req) begin
                  busy_line_oe <= 1'b1;                                 // [R20]
                  lim_r        <= REQ_CYC;
                  start_r      <= 1'b1;
               end else if (cmd_valid) begin
                  cmd_act_r <= 1'b1;
                  op_r      <= cmd_op;
                  step_r    <= 3'h0;
                  wr_r      <= 1'b0;
                  mem_addr  <= {{(AW-16){1'b0}}, `NVC_SEQ_A1};          // [R19]
                  mem_we_n  <= 1'b1;                                    // [R3]
                  mem_cs_n  <= 1'b0;                                    // [R11]
                  mem_oe_n  <= 1'b0;
                  lim_r     <= ACC_CYC;
                  start_r   <= 1'b1;
               end else if (req_valid) begin
                  wr_r          <= req_write;
                  mem_addr      <= req_addr;
                  // strobe falls with select; device has 0 ns address setup [R4]
                  mem_we_n      <= ~req_write;
                  mem_oe_n      <= req_write;
                  mem_cs_n      <= 1'b0;                                // [R1]
                  byte_lines_o  <= req_wdata;
                  byte_lines_oe <= req_write;
                  lim_r         <= ACC_CYC;
                  start_r       <= 1'b1;
               end
            end
            S_ACC: if (ph_done) begin
               mem_cs_n      <= 1'b1;
               mem_we_n      <= 1'b1;
               mem_oe_n      <= 1'b1;
               byte_lines_oe <= 1'b0;
               if (!cmd_act_r && !wr_r) begin
                  rsp_valid <= 1'b1;
                  rsp_rdata <= byte_lines_i;
               end else if (!cmd_act_r) begin
                  rsp_valid <= 1'b1;
               end
               // sixth command byte is not returned [R13]
            end
            S_GAP: begin
               if (cmd_act_r && step_r != 3'h5) begin
                  step_r   <= step_r + 3'h1;
                  mem_addr <= {{(AW-16){1'b0}}, seq_word(step_r + 3'h1, op_r)};
                  mem_cs_n <= 1'b0;
                  mem_oe_n <= 1'b0;
                  start_r  <= 1'b1;
               end else if (cmd_act_r) begin
                  cmd_act_r <= 1'b0;
                  lim_r     <= lock_len(op_r);
                  start_r   <= 1'b1;
               end
            end
            S_HREQ: if (ph_done) begin
               busy_line_oe <= 1'b0;   // release; device holds low if saving
            end
            S_HWT: if (busy_line_i) begin
               // device may keep driving high briefly after a save [R16]
               lim_r   <= BREL_CYC;
               start_r <= 1'b1;
            end
            default: ;
         endcase
      end
   end
endmodule // nvc_host

/* File: sim/nvc_host_checker.sv */
// Purpose: pin-level assertions for nvc_host
// Assumes: one clock domain, sync reset
// Notes:   bound to every nvc_host
`timescale 1ns/1ps
module nvc_host_checker (
   input wire clk_sys, rst, ce, req_valid, req_ready, cmd_valid, cmd_ready, hw_save_req,
   input wire dev_ready, rsp_valid, mem_cs_n, mem_we_n, mem_oe_n, byte_lines_oe, busy_line_oe
);
   // accepted requests; hardware save outranks command outranks access
   wire take  = ce && dev_ready && req_valid && req_ready && !cmd_valid && !hw_save_req;
   wire ctake = ce && dev_ready && cmd_valid && cmd_ready && !hw_save_req;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_rd; !mem_oe_n |-> mem_we_n && !byte_lines_oe; endproperty
   a_rd: assert property (p_rd) else $error("read with write strobe or host drive");
   property p_busy; !mem_cs_n |-> !busy_line_oe; endproperty
   a_busy: assert property (p_busy) else $error("busy pulled during access");
   property p_wz; $fell(mem_cs_n) |-> $past(mem_we_n); endproperty
   a_wz: assert property (p_wz) else $error("write strobe low at select");
   // select is launched at the take edge and lowered for three sampled cycles before the answer
   property p_acc; take |=> !mem_cs_n [*3] ##1 (mem_cs_n && rsp_valid); endproperty
   a_acc: assert property (p_acc) else $error("access timing wrong");
   property p_one; rsp_valid |=> !rsp_valid; endproperty
   a_one: assert property (p_one) else $error("response longer than one cycle");
   property p_cmd; ctake |=> !rsp_valid [*8]; endproperty
   a_cmd: assert property (p_cmd) else $error("command gave response");
   property p_lock; ctake |=> !dev_ready [*8]; endproperty
   a_lock: assert property (p_lock) else $error("command not locked out");
   property p_pwr; $fell(rst) |-> !dev_ready [*8]; endproperty
   a_pwr: assert property (p_pwr) else $error("ready too soon after reset");
   property p_hw; busy_line_oe |-> mem_cs_n && !byte_lines_oe; endproperty
   a_hw: assert property (p_hw) else $error("access during save request");
endmodule // nvc_host_checker
bind nvc_host nvc_host_checker nvc_host_checker_inst (.clk_sys, .rst, .ce, .req_valid, .req_ready, .cmd_valid,
   .cmd_ready, .hw_save_req, .dev_ready, .rsp_valid, .mem_cs_n, .mem_we_n, .mem_oe_n, .byte_lines_oe, .busy_line_oe);

/* File: sim/nvc_dev_model.sv */
// Purpose: behavioural model of the nonvolatile static memory
// Assumes: pins sampled on clk_sys; times in cycles
// Notes:   holds 256 bytes, low address byte only
`timescale 1ns/1ps
module nvc_dev_model #(parameter [15:0] SAVE_T = 16'd10, REST_T = 16'd5) (
   input  wire        clk_sys, mem_cs_n, mem_we_n, mem_oe_n, busy_w,
   input  wire [18:0] mem_addr,
   input  wire [7:0]  byte_lines_o,
   output wire [7:0]  byte_lines_i,
   output reg         dev_pull_low = 1'b0,
   output reg  [1:0]  last_cmd = 2'h0,
   output reg  [7:0]  saves = 8'h00
);
   localparam [79:0] PRE = {16'h703F, 16'h7C1F, 16'h83E0, 16'hB1C7, 16'h4E38};
   localparam [63:0] CMD = {16'h4B46, 16'h8B45, 16'h4C63, 16'h8FC0};
   reg [7:0]  mem [0:255];
   reg [7:0]  last_q = 8'h00;
   reg [15:0] lock_r = 16'd5; // power-up restore holds accesses off
   reg [2:0]  step_r = 3'h0;
   reg        in_r = 1'b0, rd_r = 1'b0, wr_r = 1'b0;
   reg [18:0] a_r = 19'h0;
   integer    i;
   wire       drv = !mem_cs_n && mem_we_n && !mem_oe_n && lock_r == 0 && step_r != 5;
   // released lines show the inverse of the last byte so stale data never passes
   assign byte_lines_i = drv ? mem[mem_addr[7:0]] : ~last_q;
   // access, command detector and save engine
   always @(posedge clk_sys) begin
      in_r <= !mem_cs_n;
      if (drv) last_q <= mem[mem_addr[7:0]];
      if (lock_r != 0) lock_r <= lock_r - 16'd1;
      else dev_pull_low <= 1'b0; // busy released once save ends
      if (!mem_cs_n && lock_r == 0) begin // ignored while locked
         a_r <= mem_addr;
         rd_r <= mem_we_n;
         if (!mem_we_n) begin
            mem[mem_addr[7:0]] <= byte_lines_o;
            wr_r <= 1'b1;
         end
      end
      if (in_r && mem_cs_n && lock_r == 0) begin
         if (!rd_r || (step_r != 5 && a_r[14:2] != PRE[step_r*16+2 +: 13])) step_r <= 3'h0;
         else if (step_r != 5) step_r <= step_r + 3'h1;
         else begin
            step_r <= 3'h0;
            for (i = 0; i < 4; i = i + 1)
               if (a_r[14:2] == CMD[i*16+2 +: 13]) begin // acts at once
                  last_cmd <= i[1:0];
                  lock_r <= (i == 0) ? SAVE_T : (i == 1) ? REST_T : 16'd1;
                  if (i == 0) wr_r <= 1'b0;
               end
         end
      end
      if (!busy_w && !dev_pull_low && lock_r == 0 && wr_r) begin // skipped if nothing written
         dev_pull_low <= 1'b1;
         lock_r <= SAVE_T;
         saves <= saves + 8'h01;
         wr_r <= 1'b0;
      end
   end
endmodule // nvc_dev_model

/* File: sim/tb.sv */
// Purpose: self-checking bench for nvc_host with a device model
// Assumes: 20 MHz clk_sys, shortened waits
// Notes:   each scenario is its own task
`timescale 1ns/1ps
module tb;
   localparam PU = 20, SV = 40, RS = 20;
   reg         clk_sys = 1'b0, rst = 1'b1, ce = 1'b1, req_valid = 1'b0, req_write = 1'b0;
   reg         cmd_valid = 1'b0, hw_save_req = 1'b0;
   reg  [18:0] req_addr = 19'h00000;
   reg  [7:0]  req_wdata = 8'h00, q;
   reg  [1:0]  cmd_op = 2'h0;
   wire        req_ready, rsp_valid, cmd_ready, dev_ready, mem_cs_n, mem_we_n, mem_oe_n;
   wire        byte_lines_oe, busy_line_o, busy_line_oe, dev_pull_low;
   wire [7:0]  rsp_rdata, byte_lines_i, byte_lines_o, saves;
   wire [18:0] mem_addr;
   wire [1:0]  last_cmd;
   integer     err_count = 0, samples_checked = 0, n, r, k;
   // pulled up unless one side pulls low
   wire        busy_line_i = busy_line_oe ? busy_line_o : !dev_pull_low;
   always #25 clk_sys = ~clk_sys;
   nvc_host #(.POWERUP_CYC(PU), .SAVE_CYC(SV), .RESTORE_CYC(RS)) nvc_host_inst (.clk_sys, .rst, .ce, .req_valid,
      .req_ready, .req_write, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .cmd_valid, .cmd_ready, .cmd_op,
      .hw_save_req, .dev_ready, .mem_addr, .mem_cs_n, .mem_we_n, .mem_oe_n, .byte_lines_i, .byte_lines_o,
      .byte_lines_oe, .busy_line_i, .busy_line_o, .busy_line_oe);
   nvc_dev_model nvc_dev_model_inst (.clk_sys, .mem_cs_n, .mem_we_n, .mem_oe_n, .busy_w(busy_line_i), .mem_addr,
      .byte_lines_o, .byte_lines_i, .dev_pull_low, .last_cmd, .saves);
   task chk(input [31:0] got, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task summarize;
      begin
         $display("checked=%0d errors=%0d", samples_checked, err_count);
         if (err_count == 0 && samples_checked > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // counts cycles to ready and responses seen meanwhile
   task wait_rdy;
      begin
         n = 0;
         r = 0;
         while (dev_ready !== 1'b1 && n < 5000) begin
            n = n + 1;
            if (rsp_valid === 1'b1) r = r + 1;
            @(posedge clk_sys);
         end
         chk(n < 5000, 1);
      end
   endtask
   task acc(input w, input [18:0] a, input [7:0] d);
      begin
         req_write <= w;
         req_addr <= a;
         req_wdata <= d;
         req_valid <= 1'b1;
         @(posedge clk_sys);
         while (req_ready !== 1'b1) @(posedge clk_sys);
         req_valid <= 1'b0;
         n = 0;
         @(posedge clk_sys);
         while (rsp_valid !== 1'b1 && n < 20) begin
            n = n + 1;
            @(posedge clk_sys);
         end
         chk(n, 3);
         q = rsp_rdata;
      end
   endtask
   task t_power;
      begin
         wait_rdy;
         chk(n >= PU, 1);
      end
   endtask
   task t_rw;
      begin
         for (k = 0; k < 8; k = k + 1) begin
            acc(k < 4, (k % 4) * 19'h1C0C1, 8'h5A + (k % 4) * 8'h33);
            if (k >= 4) chk(q, 8'h5A + (k % 4) * 8'h33);
         end
      end
   endtask
   // clock enable low refuses a pending access and freezes a running command mid-read
   task t_ce;
      begin
         ce <= 1'b0;
         req_write <= 1'b0;
         req_addr <= 19'h00000;
         req_valid <= 1'b1;
         repeat (4) @(posedge clk_sys);
         chk(req_ready, 0);
         chk(mem_cs_n, 1);
         ce <= 1'b1;
         acc(1'b0, 19'h00000, 8'h00);
         chk(q, 8'h5A);
         cmd_op <= 2'h1;
         cmd_valid <= 1'b1;
         @(posedge clk_sys);
         while (cmd_ready !== 1'b1) @(posedge clk_sys);
         cmd_valid <= 1'b0;
         repeat (2) @(posedge clk_sys);
         ce <= 1'b0;
         repeat (40) @(posedge clk_sys);
         chk(mem_addr, 19'h04E38);
         chk(mem_cs_n, 0);
         chk(dev_ready, 0);
         ce <= 1'b1;
         wait_rdy;
         chk(last_cmd, 1);
         chk(r, 0);
      end
   endtask
   // restore, both power-loss codes, then save
   task t_cmd;
      begin
         for (k = 1; k < 5; k = k + 1) begin
            cmd_op <= k[1:0];
            cmd_valid <= 1'b1;
            @(posedge clk_sys);
            while (cmd_ready !== 1'b1) @(posedge clk_sys);
            cmd_valid <= 1'b0;
            @(posedge clk_sys);
            wait_rdy;
            chk(last_cmd, k % 4);
            chk(n >= (k == 4 ? SV : k == 1 ? RS : 2000), 1);
            chk(r, 0);
         end
      end
   endtask
   // second save has nothing new to keep and must be skipped
   task t_hw;
      integer s;
      begin
         acc(1'b1, 19'h00077, 8'hC3);
         s = saves;
         for (k = 0; k < 2; k = k + 1) begin
            hw_save_req <= 1'b1;
            @(posedge clk_sys);
            while (busy_line_oe !== 1'b1) @(posedge clk_sys);
            hw_save_req <= 1'b0;
            @(posedge clk_sys);
            wait_rdy;
            chk(saves, s + 1);
         end
         acc(1'b0, 19'h00077, 8'h00);
         chk(q, 8'hC3);
      end
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      t_power;
      t_rw;
      t_ce;
      t_cmd;
      t_hw;
      summarize;
   end
   // run needs about 5000 cycles
   initial begin
      #1000000;
      err_count = err_count + 1;
      summarize;
   end
endmodule // tb
